//--- verilog/gpl_pin_cfg_low.sv
// Low pin configuration, debug overrides and debug status for three ports
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "gpl_defs.svh"

// Contract
// - Each lower pin owns a four-bit field, pin 3 highest, pin 0 lowest.
// - Reset loads every low config register with all pins floating input.
// - Code zero is analog and its input-value bit reads as one.
// - Code 1 push-pull, code 5 open-drain, both from output-value bit.
// - Code 4 floats; code 8 pulls down or up per output-value bit.
// - Codes 9 and 13 drive the pin from the peripheral output.
// - Code 11 uses the dedicated SPI-master serial clock push-pull path on pins 2 and 7; other pins drive push-pull from peripheral output.
// - Debug config register holds debugger disable and other control bits.
// - Read-only debug status shows forced debug and serial-wire enable.
// - Status keeps the inverted boot-select pin level seen at the last reset.
// - During reset the boot-select pin is an input with pull-up.
// - JTAG mode makes test reset, data-in, mode-select pulled-up inputs.
// - JTAG mode makes the test data-out pin a push-pull output.
// - Serial-wire mode lets the debugger set data pin direction.
// - Second timer channels sit on port A pins or remapped port B pins.
// - Output and alternate modes switch both pin resistors off.
// - Open-drain zero sinks, one floats; push-pull one sources.
module gpl_pin_cfg_low (
	input  wire logic                 mclk_i,
	input  wire logic                 external_reset_pin_n_i,
	input  wire logic                 ce_i,
	input  wire gpl_pkg::gpl_avs_req_t avs_i,
	output logic [31:0]               avs_readdata_o,
	output logic                      avs_waitrequest_o,
	input  wire logic [11:0]          pad_in_i,
	output logic [11:0]               pad_out_o,
	output logic [11:0]               pad_oe_o,
	output logic [11:0]               pad_pu_o,
	output logic [11:0]               pad_pd_o,
	output logic [11:0]               pad_analog_o,
	output logic [11:0]               port_input_value_o,
	input  wire logic [11:0]          port_output_value_i,
	input  wire logic [11:0]          alt_out_i,
	input  wire logic                 serial_ctrl_one_clock_i,
	input  wire logic                 serial_ctrl_two_clock_i,
	input  wire logic [3:0]           timer_b_out_i,
	input  wire logic [3:0]           timer_b_oe_i,
	output logic [3:0]                timer_b_in_o,
	input  wire logic                 boot_select_pin_n_i,
	output logic                      boot_pin_pullup_o,
	output logic                      boot_pin_latched_o,
	input  wire logic                 jtag_mode_i,
	input  wire logic                 sw_mode_i,
	input  wire logic                 debug_forced_i,
	input  wire logic                 tap_data_out_i,
	input  wire logic                 swdio_out_i,
	input  wire logic                 swdio_oe_i,
	input  wire logic                 pc4_in_i,
	output logic                      pc4_ovr_o,
	output logic                      pc4_out_o,
	output logic                      pc4_oe_o,
	output logic                      pc4_pu_o,
	output logic                      debug_disable_o,
	output logic                      timer_b_remap_o
);
	gpl_pkg::gpl_state_t q;
	gpl_pkg::gpl_state_t d;

	// Timer channel pin per mapping; out-of-block pin gives none
	function automatic logic [3:0] tmr_pin(input logic [1:0] ch, input logic map);
		logic [3:0] p;
		p = `GPL_PIN_NONE;
		unique case (ch)
			2'h0: p = map ? 4'h5 : 4'h0;
			2'h1: p = map ? 4'h6 : 4'h3;
			2'h2: p = map ? 4'h7 : 4'h1;
			2'h3: p = map ? `GPL_PIN_NONE : 4'h2;
		endcase
		return p;
	endfunction : tmr_pin

	logic        jt;
	logic        sw;
	logic        acc;
	logic        wr_ok;
	logic [3:0]  code;
	logic [3:0]  tp;
	logic        v;
	logic        a;
	logic        sc;
	logic [31:0] mux;

	always_comb begin
		d     = q;
		jt    = jtag_mode_i & ~q.dbg_dis;
		sw    = sw_mode_i & ~q.dbg_dis & ~jt;
		acc   = (avs_i.read | avs_i.write) & q.waitreq;
		wr_ok = avs_i.write & ~q.waitreq;
		code  = '0;
		tp    = '0;
		v     = 1'b0;
		a     = 1'b0;
		sc    = 1'b0;
		mux   = '0;
		d.s1      = pad_in_i;
		d.s2      = q.s1;
		d.boot_s1 = boot_select_pin_n_i;
		d.boot_s2 = q.boot_s1;
		// Boot pin held pulled up until its synchronised level is caught
		if (q.rst_cnt != `GPL_RST_DONE_CNT) begin
			d.rst_cnt = q.rst_cnt + 2'h1;
		end
		d.boot_ovr = (q.rst_cnt < `GPL_BOOT_LATCH_CNT);
		if (q.rst_cnt == `GPL_BOOT_LATCH_CNT) begin
			d.boot_flag = ~q.boot_s2;
		end
		for (int j = 0; j < 4; j++) begin
			tp = tmr_pin(2'(j), q.remap);
			d.tmr_in[j] = (tp == `GPL_PIN_NONE) ? 1'b0 : q.s2[tp];
		end
		for (int i = 0; i < 12; i++) begin
			code = q.cfg[i / 4][(i % 4) * `GPL_FIELD_W +: `GPL_FIELD_W];
			v    = port_output_value_i[i];
			a    = alt_out_i[i];
			for (int j = 0; j < 4; j++) begin
				if (timer_b_oe_i[j] && tmr_pin(2'(j), q.remap) == 4'(i)) begin
					a = timer_b_out_i[j];
				end
			end
			sc = a;
			if (i == `GPL_PIN_SCLK_TWO) begin
				sc = serial_ctrl_two_clock_i;
			end
			if (i == `GPL_PIN_SCLK_ONE) begin
				sc = serial_ctrl_one_clock_i;
			end
			d.pout[i] = 1'b0;
			d.poe[i]  = 1'b0;
			d.ppu[i]  = 1'b0;
			d.ppd[i]  = 1'b0;
			d.pana[i] = 1'b0;
			case (code)
				`GPL_CODE_ANALOG: d.pana[i] = 1'b1;
				`GPL_CODE_OUT_PP: begin
					d.poe[i]  = 1'b1;
					d.pout[i] = v;
				end
				`GPL_CODE_IN_FLOAT: d.poe[i] = 1'b0;
				`GPL_CODE_OUT_OD: d.poe[i] = ~v;
				`GPL_CODE_IN_PULL: begin
					d.ppu[i] = v;
					d.ppd[i] = ~v;
				end
				`GPL_CODE_ALT_PP: begin
					d.poe[i]  = 1'b1;
					d.pout[i] = a;
				end
				`GPL_CODE_ALT_SCLK: begin
					d.poe[i]  = 1'b1;
					d.pout[i] = sc;
				end
				`GPL_CODE_ALT_OD: d.poe[i] = ~a;
				default: d.poe[i] = 1'b0;
			endcase
			// Overrides sit after the field decode so they win
			if (jt && (i == `GPL_PIN_TAP_RST || i == `GPL_PIN_TAP_DI)) begin
				d.poe[i]  = 1'b0;
				d.ppu[i]  = 1'b1;
				d.ppd[i]  = 1'b0;
				d.pana[i] = 1'b0;
			end
			if (jt && i == `GPL_PIN_TAP_DO) begin
				d.poe[i]  = 1'b1;
				d.pout[i] = tap_data_out_i;
				d.ppu[i]  = 1'b0;
				d.ppd[i]  = 1'b0;
				d.pana[i] = 1'b0;
			end
			d.inval[i] = d.pana[i] | q.s2[i];
		end
		// Mode-select and serial-wire data share the pin above this block
		d.pc4_ovr = jt | sw;
		d.pc4_pu  = jt;
		d.pc4_oe  = sw & swdio_oe_i;
		d.pc4_out = sw & swdio_out_i;
		d.waitreq = 1'b1;
		unique case (avs_i.address)
			`GPL_CFGL_A_OFS: mux = {16'h0, q.cfg[0]};
			`GPL_CFGL_B_OFS: mux = {16'h0, q.cfg[1]};
			`GPL_CFGL_C_OFS: mux = {16'h0, q.cfg[2]};
			`GPL_DBG_CFG_OFS: begin
				mux[`GPL_DBGCFG_DIS_BIT] = q.dbg_dis;
				mux[`GPL_DBGCFG_MAP_BIT] = q.remap;
			end
			`GPL_DBG_STAT_OFS: begin
				mux[`GPL_STAT_FORCE_BIT] = debug_forced_i;
				mux[`GPL_STAT_SWEN_BIT]  = sw;
				mux[`GPL_STAT_BOOT_BIT]  = q.boot_flag;
			end
			default: mux = '0;
		endcase
		if (acc) begin
			d.waitreq = 1'b0;
			d.rdata   = avs_i.read ? mux : 32'h0;
		end
		if (wr_ok) begin
			for (int p = 0; p < 3; p++) begin
				if (avs_i.address == (p == 0 ? `GPL_CFGL_A_OFS :
						p == 1 ? `GPL_CFGL_B_OFS : `GPL_CFGL_C_OFS)) begin
					for (int b = 0; b < 2; b++) begin
						if (avs_i.byteenable[b]) begin
							d.cfg[p][b*8 +: 8] = avs_i.writedata[b*8 +: 8];
						end
					end
				end
			end
			if (avs_i.address == `GPL_DBG_CFG_OFS && avs_i.byteenable[0]) begin
				d.dbg_dis = avs_i.writedata[`GPL_DBGCFG_DIS_BIT];
				d.remap   = avs_i.writedata[`GPL_DBGCFG_MAP_BIT];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge external_reset_pin_n_i) begin
		if (!external_reset_pin_n_i) begin
			q          <= '0;
			q.cfg      <= {3{`GPL_CFGL_RST}};
			q.boot_s1  <= 1'b1;
			q.boot_s2  <= 1'b1;
			q.boot_ovr <= 1'b1;
			q.waitreq  <= 1'b1;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign avs_readdata_o     = q.rdata;
	assign avs_waitrequest_o  = q.waitreq;
	assign pad_out_o          = q.pout;
	assign pad_oe_o           = q.poe;
	assign pad_pu_o           = q.ppu;
	assign pad_pd_o           = q.ppd;
	assign pad_analog_o       = q.pana;
	assign port_input_value_o = q.inval;
	assign timer_b_in_o       = q.tmr_in;
	assign boot_pin_pullup_o  = q.boot_ovr;
	assign boot_pin_latched_o = q.boot_flag;
	assign pc4_ovr_o          = q.pc4_ovr;
	assign pc4_out_o          = q.pc4_out;
	assign pc4_oe_o           = q.pc4_oe;
	assign pc4_pu_o           = q.pc4_pu;
	assign debug_disable_o    = q.dbg_dis;
	assign timer_b_remap_o    = q.remap;

	property p_cfg_reset;
		@(posedge mclk_i) $rose(external_reset_pin_n_i) |-> q.cfg == {3{`GPL_CFGL_RST}};
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("cfg reset value wrong");
	property p_analog_reads_one;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			q.cfg[2][7:4] == `GPL_CODE_ANALOG |=> q.inval[9] && q.pana[9];
	endproperty
	a_analog_reads_one: assert property (p_analog_reads_one) else $error("analog bit");
	property p_push_pull;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			q.cfg[0][7:4] == `GPL_CODE_OUT_PP ##0 port_output_value_i[1]
			|=> q.poe[1] && q.pout[1] && !q.ppu[1] && !q.ppd[1];
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");
	property p_open_drain_float;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			q.cfg[0][7:4] == `GPL_CODE_OUT_OD && port_output_value_i[1] |=> !q.poe[1];
	endproperty
	a_open_drain_float: assert property (p_open_drain_float) else $error("od one");
	property p_pull_down;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			q.cfg[0][7:4] == `GPL_CODE_IN_PULL && !port_output_value_i[1]
			|=> q.ppd[1] && !q.ppu[1] && !q.poe[1];
	endproperty
	a_pull_down: assert property (p_pull_down) else $error("pull select wrong");
	property p_alt_drive;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			q.cfg[2][7:4] == `GPL_CODE_ALT_PP |=> q.poe[9] && q.pout[9] == $past(alt_out_i[9]);
	endproperty
	a_alt_drive: assert property (p_alt_drive) else $error("alt output wrong");
	property p_tap_inputs;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			jtag_mode_i && !q.dbg_dis |=> q.ppu[8] && !q.poe[8] && q.ppu[11] && q.pc4_pu;
	endproperty
	a_tap_inputs: assert property (p_tap_inputs) else $error("tap inputs");
	property p_tap_out;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			jtag_mode_i && !q.dbg_dis |=> q.poe[10] && q.pout[10] == $past(tap_data_out_i);
	endproperty
	a_tap_out: assert property (p_tap_out) else $error("tap data out");
	property p_field_resumes;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			!jtag_mode_i && q.cfg[2][3:0] == `GPL_CODE_OUT_PP |=> q.poe[8] && !q.ppu[8];
	endproperty
	a_field_resumes: assert property (p_field_resumes) else $error("no resume");
	property p_boot_hold;
		@(posedge mclk_i) disable iff (!external_reset_pin_n_i || !ce_i)
			q.rst_cnt == `GPL_RST_DONE_CNT |=> $stable(q.boot_flag) && !q.boot_ovr;
	endproperty
	a_boot_hold: assert property (p_boot_hold) else $error("boot flag moved");
endmodule : gpl_pin_cfg_low

//--- verilog/gpl_defs.svh
// Register offsets, field layout, reset values and timing for the low pin config block
`ifndef GPL_DEFS_SVH
`define GPL_DEFS_SVH
`define GPL_CFGL_A_OFS     16'hb000
`define GPL_CFGL_B_OFS     16'hb400
`define GPL_CFGL_C_OFS     16'hb800
`define GPL_DBG_CFG_OFS    16'hbc20
`define GPL_DBG_STAT_OFS   16'hbc24
`define GPL_CFGL_RST       16'h4444
`define GPL_FIELD_W        4
`define GPL_DBGCFG_DIS_BIT 0
`define GPL_DBGCFG_MAP_BIT 1
`define GPL_STAT_FORCE_BIT 0
`define GPL_STAT_SWEN_BIT  1
`define GPL_STAT_BOOT_BIT  2
`define GPL_CODE_ANALOG    4'h0
`define GPL_CODE_OUT_PP    4'h1
`define GPL_CODE_IN_FLOAT  4'h4
`define GPL_CODE_OUT_OD    4'h5
`define GPL_CODE_IN_PULL   4'h8
`define GPL_CODE_ALT_PP    4'h9
`define GPL_CODE_ALT_SCLK  4'hb
`define GPL_CODE_ALT_OD    4'hd
`define GPL_PIN_SCLK_TWO   2
`define GPL_PIN_SCLK_ONE   7
`define GPL_PIN_TAP_RST    8
`define GPL_PIN_TAP_DO     10
`define GPL_PIN_TAP_DI     11
`define GPL_PIN_NONE       4'hc
`define GPL_BOOT_LATCH_CNT 2'h2
`define GPL_RST_DONE_CNT   2'h3
`endif

//--- verilog/gpl_pkg.sv
// Types shared by the low pin config block
package gpl_pkg;
	typedef struct packed {
		logic [15:0] address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} gpl_avs_req_t;

	typedef struct packed {
		logic [2:0][15:0] cfg;
		logic             dbg_dis;
		logic             remap;
		logic [11:0]      s1;
		logic [11:0]      s2;
		logic             boot_s1;
		logic             boot_s2;
		logic [1:0]       rst_cnt;
		logic             boot_flag;
		logic             boot_ovr;
		logic [11:0]      pout;
		logic [11:0]      poe;
		logic [11:0]      ppu;
		logic [11:0]      ppd;
		logic [11:0]      pana;
		logic [11:0]      inval;
		logic [3:0]       tmr_in;
		logic             pc4_ovr;
		logic             pc4_out;
		logic             pc4_oe;
		logic             pc4_pu;
		logic [31:0]      rdata;
		logic             waitreq;
	} gpl_state_t;
endpackage : gpl_pkg

//--- verif/gpl_pin_world.sv
// Pin-side model: resolves each pad level from drive and pulls
`timescale 1ns/1ps
module gpl_pin_world (
	input  wire logic        mclk_i,
	input  wire logic [11:0] pad_out_i,
	input  wire logic [11:0] pad_oe_i,
	input  wire logic [11:0] pad_pu_i,
	input  wire logic [11:0] pad_pd_i,
	output logic [11:0]      pad_in_o
);
	logic [11:0] wander_q = 12'h5a5;
	// Undriven and unpulled pads change every cycle
	always @(posedge mclk_i) begin
		wander_q <= ~wander_q;
	end
	// Open-drain: oe with out 0 sinks, no oe floats
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			pad_in_o[i] = pad_oe_i[i] ? pad_out_i[i] : pad_pu_i[i] ? 1'b1 :
				pad_pd_i[i] ? 1'b0 : wander_q[i];
		end
	end
endmodule : gpl_pin_world

//--- verif/gpl_pin_cfg_low_test.sv
// Self-checking bench of the low pin configuration block
`timescale 1ns/1ps
module gpl_pin_cfg_low_test;
	logic mclk_i = 0, external_reset_pin_n_i = 0, ce_i = 1, pc4_in_i = 0;
	gpl_pkg::gpl_avs_req_t avs_i = '0;
	logic [31:0] avs_readdata_o, rdata;
	logic avs_waitrequest_o, boot_pin_pullup_o, boot_pin_latched_o;
	logic [11:0] pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, pad_pd_o, pad_analog_o;
	logic [11:0] port_input_value_o, port_output_value_i = 0, alt_out_i = 0;
	logic serial_ctrl_one_clock_i = 0, serial_ctrl_two_clock_i = 0, boot_select_pin_n_i = 1;
	logic [3:0] timer_b_out_i = 0, timer_b_oe_i = 0, timer_b_in_o;
	logic jtag_mode_i = 0, sw_mode_i = 0, debug_forced_i = 0, tap_data_out_i = 0;
	logic swdio_out_i = 0, swdio_oe_i = 0, pc4_ovr_o, pc4_out_o, pc4_oe_o, pc4_pu_o;
	logic debug_disable_o, timer_b_remap_o;
	int fail_count = 0, cmp_count = 0, cyc = 0, p;
	logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hb, 4'hd, 4'h2};
	logic [3:0] c;
	logic ob, ab, sk;
	logic [11:0] ov;

	gpl_pin_cfg_low dut (.mclk_i, .external_reset_pin_n_i, .ce_i, .avs_i, .avs_readdata_o, .avs_waitrequest_o,
		.pad_in_i, .pad_out_o, .pad_oe_o, .pad_pu_o, .pad_pd_o, .pad_analog_o,
		.port_input_value_o, .port_output_value_i, .alt_out_i, .serial_ctrl_one_clock_i,
		.serial_ctrl_two_clock_i, .timer_b_out_i, .timer_b_oe_i, .timer_b_in_o,
		.boot_select_pin_n_i, .boot_pin_pullup_o, .boot_pin_latched_o, .jtag_mode_i,
		.sw_mode_i, .debug_forced_i, .tap_data_out_i, .swdio_out_i, .swdio_oe_i, .pc4_in_i,
		.pc4_ovr_o, .pc4_out_o, .pc4_oe_o, .pc4_pu_o, .debug_disable_o, .timer_b_remap_o);
	gpl_pin_world world (.mclk_i(mclk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
		.pad_pu_i(pad_pu_o), .pad_pd_i(pad_pd_o), .pad_in_o(pad_in_i));

	always #20 mclk_i = ~mclk_i;

	task end_sim;
		$display("counts: %0d compared, %0d failed", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check

	// One Avalon access, entered just after a rising edge
	task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		avs_i.address <= a;
		avs_i.read <= ~w;
		avs_i.write <= w;
		avs_i.writedata <= d;
		avs_i.byteenable <= 4'hf;
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
		rdata = avs_readdata_o;
		avs_i.read <= 1'b0;
		avs_i.write <= 1'b0;
		@(posedge mclk_i);
	endtask : bus

	function automatic logic [4:0] exp_pin(logic [3:0] cd, logic o, logic a, logic s);
		case (cd)
			4'h0: return 5'b00001;
			4'h1: return {1'b1, o, 3'b000};
			4'h5: return {~o, 4'b0000};
			4'h8: return {2'b00, o, ~o, 1'b0};
			4'h9: return {1'b1, a, 3'b000};
			4'hb: return {1'b1, s, 3'b000};
			4'hd: return {~a, 4'b0000};
			default: return 5'b00000;
		endcase
	endfunction : exp_pin

	task set_field(input int pin, input logic [3:0] cd);
		logic [15:0] v;
		v = 16'h4444;
		v[(pin % 4) * 4 +: 4] = cd;
		bus(1'b1, 16'hb000 + 16'((pin / 4) * 16'h400), {16'hffff, v});
		bus(1'b0, 16'hb000 + 16'((pin / 4) * 16'h400), 32'h0);
		check(rdata, {16'h0, v}, "cfg readback");
	endtask : set_field

	task settle;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask : settle

	initial begin
		rdata = $urandom(32'h6e65);
		repeat (20) @(posedge mclk_i);
		external_reset_pin_n_i <= 1'b1;
		@(posedge mclk_i);
		for (int k = 0; k < 3; k++) begin
			bus(1'b0, 16'hb000 + 16'(k * 16'h400), 32'h0);
			check(rdata, 32'h4444, "cfg reset");
		end
		bus(1'b0, 16'hbc24, 32'h0);
		check(rdata[2], 1'b0, "boot flag");
		bus(1'b0, 16'hb0f0, 32'h0);
		check(rdata, 32'h0, "unmapped");
		$display("test reset values done");
		for (int k = 0; k < 9; k++) begin
			for (int j = 0; j < 4; j++) begin
				c = codes[k];
				p = (j == 0) ? $urandom_range(11) : (j == 1) ? ((k % 2) ? 7 : 2) :
					(k == 0 || k == 5) ? 9 : 1;
				// Pins 1 and 9 with a known output bit reach the assertions
				ov = 12'($urandom);
				if (j > 1)
					ov[p] = j[0];
				port_output_value_i <= ov;
				alt_out_i <= 12'($urandom);
				serial_ctrl_one_clock_i <= 1'($urandom);
				serial_ctrl_two_clock_i <= 1'($urandom);
				set_field(p, c);
				@(negedge mclk_i);
				ob = port_output_value_i[p];
				ab = alt_out_i[p];
				sk = (p == 7) ? serial_ctrl_one_clock_i : serial_ctrl_two_clock_i;
				sk = (p == 7 || p == 2) ? sk : ab;
				check({pad_oe_o[p], pad_out_o[p] & pad_oe_o[p], pad_pu_o[p], pad_pd_o[p],
					pad_analog_o[p]}, exp_pin(c, ob, ab, sk), "pin mode");
				repeat (4) @(negedge mclk_i);
				if (c < 4'h2)
					check(port_input_value_o[p], c == 4'h0 ? 1'b1 : ob, "input val");
				@(posedge mclk_i);
			end
		end
		$display("test pin modes done");
		bus(1'b1, 16'hb800, 32'h1111);
		port_output_value_i <= 12'hf00;
		jtag_mode_i <= 1'b1;
		tap_data_out_i <= 1'b1;
		debug_forced_i <= 1'b1;
		settle();
		check({pad_oe_o[8], pad_pu_o[8], pad_oe_o[11], pad_pu_o[11]}, 4'h5, "tap in");
		check({pad_oe_o[10], pad_out_o[10], pad_oe_o[9]}, 3'b111, "tap out");
		@(posedge mclk_i);
		bus(1'b0, 16'hbc24, 32'h0);
		check(rdata[2:0], 3'b001, "status jtag");
		jtag_mode_i <= 1'b0;
		sw_mode_i <= 1'b1;
		swdio_oe_i <= 1'b1;
		swdio_out_i <= 1'b1;
		settle();
		check({pc4_ovr_o, pc4_oe_o, pc4_out_o}, 3'b111, "swdio out");
		check({pad_oe_o[8], pad_pu_o[8]}, 2'b10, "field back");
		@(posedge mclk_i);
		swdio_oe_i <= 1'b0;
		bus(1'b0, 16'hbc24, 32'h0);
		check(rdata[2:0], 3'b011, "status sw");
		settle();
		check({pc4_oe_o, pc4_pu_o}, 2'b00, "swdio in");
		@(posedge mclk_i);
		bus(1'b1, 16'hbc20, 32'h1);
		jtag_mode_i <= 1'b1;
		bus(1'b0, 16'hbc20, 32'h0);
		check({rdata[0], debug_disable_o}, 2'b11, "disable");
		settle();
		check({pad_oe_o[11], pad_pu_o[11]}, 2'b10, "no override");
		@(posedge mclk_i);
		jtag_mode_i <= 1'b0;
		sw_mode_i <= 1'b0;
		bus(1'b1, 16'hbc20, 32'h2);
		timer_b_oe_i <= 4'h1;
		timer_b_out_i <= 4'h1;
		alt_out_i <= 12'h0;
		set_field(5, 4'h9);
		@(negedge mclk_i);
		check({timer_b_remap_o, pad_oe_o[5], pad_out_o[5]}, 3'b111, "remap");
		settle();
		// Remapped channel 1 reads its driven pin; channel 4 is off-block
		check({timer_b_in_o[3], timer_b_in_o[0]}, 2'b01, "timer in");
		@(posedge mclk_i);
		ce_i <= 1'b0;
		port_output_value_i <= 12'he00;
		settle();
		check(pad_out_o[8], 1'b1, "ce freeze");
		@(posedge mclk_i);
		ce_i <= 1'b1;
		settle();
		check(pad_out_o[8], 1'b0, "ce run");
		$display("test debug done");
		@(posedge mclk_i);
		external_reset_pin_n_i <= 1'b0;
		boot_select_pin_n_i <= 1'b0;
		@(negedge mclk_i);
		check(boot_pin_pullup_o, 1'b1, "boot pullup");
		repeat (20) @(posedge mclk_i);
		external_reset_pin_n_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		boot_select_pin_n_i <= 1'b1;
		bus(1'b0, 16'hbc24, 32'h0);
		check({rdata[2], boot_pin_latched_o, boot_pin_pullup_o}, 3'b110, "boot latch");
		$display("test boot done");
		end_sim();
	end
endmodule : gpl_pin_cfg_low_test
